// *** src/jamp_defs.vh ***
`ifndef JAMP_DEFS_VH
`define JAMP_DEFS_VH
`define JAMP_ST_NORMAL   2'h0
`define JAMP_ST_START    2'h1
`define JAMP_ST_TRIP     2'h2
`define JAMP_ST_BLOCKED  2'h3
`define JAMP_EVT_START   2'h0
`define JAMP_EVT_TRIP    2'h1
`define JAMP_EVT_BLOCK   2'h2
`define JAMP_SEL_ON      2'h1
`define JAMP_SEL_OFF     2'h2
`define JAMP_REC_DEPTH   12
`define JAMP_CLK_HZ      25000000
`define JAMP_RES_US      5000
`define JAMP_RES_CYC     ((`JAMP_CLK_HZ / 1000000) * `JAMP_RES_US)
`define JAMP_BLK_LEAD_MS 5
`endif

// *** src/jamp_core.v ***
// What this block does
// R1: status code 0 normal, 1 started, 2 tripped, 3 blocked.
// R2: blocking input sampled once at each program cycle start, held all cycle.
// R3: pick-up with blocking inactive asserts START and starts operate timing.
// R4: pick-up with blocking active asserts BLOCKED, no timing or trip.
// R5: blocking during START drops START and runs release timing as on reset.
// R6: entering blocked raises display pulse and stamped block event with data.
// R7: software test switch drives blocking only while stage forcing is enabled.
// R8: blocking source must assert 5 ms before operate delay expires.
// R9: separate ON/OFF events per output, stored per user ON/OFF/both selection.
// R10: every event carries time stamp and captured process data.
// R11: twelve most recent operation records are retained.
// R12: record created only on ON transitions of START, TRIP, BLOCKED.
// R13: record holds time, event, fault type, currents, remaining time, group.
// R14: expected operating time in 5 ms steps, recomputed when current changes.
// R15: signed countdown of time left to trip in 5 ms steps.
// R16: highest current to pick-up setting ratio in 0.01 steps.
// R17: START only when pick-up active and blocking inactive.
// R18: definite-time operate delay between START and TRIP.
// R19: thirteenth record overwrites the oldest, circular storage.
`timescale 1ns/1ns
`include "jamp_defs.vh"
module jamp_core #(
  parameter CW    = 16,
  parameter TW    = 48,
  parameter TMW   = 20,
  parameter DEPTH = `JAMP_REC_DEPTH
) (
  input  wire            CLK,
  input  wire            SYS_RST,
  input  wire            CYCLE_TICK,
  input  wire            PICKUP,
  input  wire            BLOCK_IN,
  input  wire            TEST_BLOCK_SW,
  input  wire            STAGE_FORCE_EN,
  input  wire [TMW-1:0]  OPERATE_DELAY,
  input  wire [TMW-1:0]  RELEASE_DELAY,
  input  wire [CW-1:0]   I_MAX,
  input  wire [CW-1:0]   I_SET,
  input  wire [CW-1:0]   I_PRE20,
  input  wire [CW-1:0]   I_PRE200,
  input  wire [3:0]      FAULT_TYPE,
  input  wire [2:0]      SETTING_GROUP_INDEX,
  input  wire [TW-1:0]   TIME_STAMP,
  input  wire [5:0]      EVT_SEL,
  input  wire [3:0]      REC_RD_IDX,
  output reg  [1:0]      STATUS,
  output reg             START,
  output reg             TRIP,
  output reg             BLOCKED,
  output reg             HMI_BLOCK_NOTE,
  output reg             EVT_VALID,
  output reg  [1:0]      EVT_CODE,
  output reg             EVT_ON,
  output reg  [TW-1:0]   EVT_TIME,
  output reg  [CW-1:0]   EVT_CURRENT,
  output reg  [3:0]      EVT_FAULT,
  output reg  [TMW-1:0]  EXP_OP_TIME,
  output reg  [TMW:0]    TIME_TO_TRIP,
  output reg  [CW-1:0]   RATIO,
  output reg  [TW+2+4+4*CW+TMW+3-1:0] REC_RD_DATA,
  output reg  [3:0]      REC_COUNT
);
  localparam RW = TW + 2 + 4 + 4 * CW + TMW + 3;
  localparam [31:0] RES_CYC_W = `JAMP_RES_CYC;
  localparam [21:0] RES_CYC = RES_CYC_W[21:0];
  reg            blk_q;
  reg            pick_q;
  reg  [21:0]    res_cnt_q;
  reg  [TMW-1:0] op_cnt_q;
  reg  [TMW-1:0] rel_cnt_q;
  reg            releasing_q;
  reg  [CW-1:0]  imax_q;
  reg  [RW-1:0]  rec_mem [0:DEPTH-1];
  reg  [3:0]     wr_ptr_q;
  reg            rec_we;
  reg  [1:0]     rec_code;
  reg            st_d;
  reg            tr_d;
  reg            bl_d;
  wire           blk_src = STAGE_FORCE_EN ? (BLOCK_IN | TEST_BLOCK_SW) : BLOCK_IN; // R7
  wire           res_tick = (res_cnt_q == RES_CYC - 22'h1);
  wire [TMW-1:0] remaining = OPERATE_DELAY - op_cnt_q;

  // ratio in hundredths; divider is costly but runs on settled settings
  function [CW-1:0] ratio_f;
    input [CW-1:0] num;
    input [CW-1:0] den;
    reg   [CW+6:0] prod;
    reg   [CW+6:0] quo;
    begin
      prod = {7'h00, num} * 7'h64;
      quo  = (den == {CW{1'b0}}) ? {(CW+7){1'b1}} : prod / {7'h00, den};
      // saturate rather than wrap when the ratio outgrows the output
      ratio_f = (quo[CW+6:CW] != 7'h00) ? {CW{1'b1}} : quo[CW-1:0];
    end
  endfunction

  always @*
  begin
    st_d = START;
    tr_d = TRIP;
    bl_d = BLOCKED;
    if (!pick_q)
    begin
      st_d = 1'b0;
      tr_d = 1'b0;
      bl_d = 1'b0;
    end
    else if (blk_q)
    begin
      st_d = 1'b0; // R5
      tr_d = 1'b0;
      bl_d = !START && !TRIP ? 1'b1 : BLOCKED; // R4
    end
    else if (!BLOCKED)
    begin
      st_d = !TRIP; // R3 R17
      tr_d = TRIP || (START && op_cnt_q >= OPERATE_DELAY); // R18
    end
  end

  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      blk_q          <= 1'b0;
      pick_q         <= 1'b0;
      res_cnt_q      <= 22'h000000;
      op_cnt_q       <= {TMW{1'b0}};
      rel_cnt_q      <= {TMW{1'b0}};
      releasing_q    <= 1'b0;
      imax_q         <= {CW{1'b0}};
      STATUS         <= `JAMP_ST_NORMAL;
      START          <= 1'b0;
      TRIP           <= 1'b0;
      BLOCKED        <= 1'b0;
      HMI_BLOCK_NOTE <= 1'b0;
      EVT_VALID      <= 1'b0;
      EVT_CODE       <= 2'h0;
      EVT_ON         <= 1'b0;
      EVT_TIME       <= {TW{1'b0}};
      EVT_CURRENT    <= {CW{1'b0}};
      EVT_FAULT      <= 4'h0;
      EXP_OP_TIME    <= {TMW{1'b0}};
      TIME_TO_TRIP   <= {(TMW+1){1'b0}};
      RATIO          <= {CW{1'b0}};
      wr_ptr_q       <= 4'h0;
      REC_COUNT      <= 4'h0;
    end
    else
    begin
      res_cnt_q      <= res_tick ? 22'h000000 : res_cnt_q + 22'h1;
      HMI_BLOCK_NOTE <= 1'b0;
      EVT_VALID      <= 1'b0;
      RATIO          <= ratio_f(I_MAX, I_SET); // R16
      if (CYCLE_TICK)
      begin
        blk_q  <= blk_src; // R2
        pick_q <= PICKUP;
      end
      else
      begin
        START   <= st_d;
        TRIP    <= tr_d;
        BLOCKED <= bl_d;
        STATUS  <= tr_d ? `JAMP_ST_TRIP : st_d ? `JAMP_ST_START :
                   bl_d ? `JAMP_ST_BLOCKED : `JAMP_ST_NORMAL; // R1
        if (START && !st_d && !tr_d)
        begin
          releasing_q <= 1'b1; // R5
          rel_cnt_q   <= {TMW{1'b0}};
        end
        if (!START && st_d)
          op_cnt_q <= {TMW{1'b0}};
        if (bl_d && !BLOCKED)
          HMI_BLOCK_NOTE <= 1'b1; // R6
        if (rec_we)
        begin
          EVT_VALID   <= 1'b1; // R9 R10
          EVT_CODE    <= rec_code;
          EVT_ON      <= (st_d & !START) | (tr_d & !TRIP) | (bl_d & !BLOCKED);
          EVT_TIME    <= TIME_STAMP;
          EVT_CURRENT <= I_MAX;
          EVT_FAULT   <= FAULT_TYPE; // R6
        end
      end
      if (res_tick)
      begin
        if (START && op_cnt_q < OPERATE_DELAY)
          op_cnt_q <= op_cnt_q + {{(TMW-1){1'b0}}, 1'b1};
        if (releasing_q)
        begin
          // release time ends the hold of the operate counter
          if (rel_cnt_q >= RELEASE_DELAY)
          begin
            releasing_q <= 1'b0;
            op_cnt_q    <= {TMW{1'b0}};
          end
          else
            rel_cnt_q <= rel_cnt_q + {{(TMW-1){1'b0}}, 1'b1};
        end
      end
      imax_q <= I_MAX;
      if (imax_q != I_MAX || !START)
        EXP_OP_TIME <= OPERATE_DELAY; // R14
      TIME_TO_TRIP <= START ? {1'b0, remaining} :
                      TRIP ? {(TMW+1){1'b0}} : {1'b0, OPERATE_DELAY}; // R15
      if (rec_we && ((st_d & !START) | (tr_d & !TRIP) | (bl_d & !BLOCKED)) && !CYCLE_TICK)
      begin
        wr_ptr_q <= (wr_ptr_q == DEPTH - 1) ? 4'h0 : wr_ptr_q + 4'h1; // R19
        if (REC_COUNT != DEPTH)
          REC_COUNT <= REC_COUNT + 4'h1; // R11
      end
    end
  end

  // event selection: bit 2k = store ON, bit 2k+1 = store OFF, per output k
  always @*
  begin
    rec_we   = 1'b0;
    rec_code = `JAMP_EVT_START;
    if (tr_d != TRIP)
    begin
      rec_code = `JAMP_EVT_TRIP;
      rec_we   = tr_d ? EVT_SEL[2] : EVT_SEL[3]; // R9
    end
    else if (bl_d != BLOCKED)
    begin
      rec_code = `JAMP_EVT_BLOCK;
      rec_we   = bl_d ? EVT_SEL[4] : EVT_SEL[5];
    end
    else if (st_d != START)
      rec_we = st_d ? EVT_SEL[0] : EVT_SEL[1];
  end

  always @(posedge CLK)
  begin
    if (!SYS_RST && !CYCLE_TICK && rec_we &&
        ((st_d & !START) | (tr_d & !TRIP) | (bl_d & !BLOCKED))) // R12
      rec_mem[wr_ptr_q] <= {TIME_STAMP, rec_code, FAULT_TYPE, I_PRE20, I_MAX,
                            I_PRE200, I_SET, remaining, SETTING_GROUP_INDEX}; // R13
    REC_RD_DATA <= rec_mem[REC_RD_IDX];
  end
endmodule // jamp_core

// *** verif/jamp_core_sva.sv ***
`timescale 1ns/1ns
module jamp_core_sva #(
  parameter TMW = 20
) (
  input wire         CLK,
  input wire         SYS_RST,
  input wire [1:0]   STATUS,
  input wire         START,
  input wire         TRIP,
  input wire         BLOCKED,
  input wire         HMI_BLOCK_NOTE,
  input wire         EVT_VALID,
  input wire [1:0]   EVT_CODE,
  input wire [TMW:0] TIME_TO_TRIP,
  input wire [3:0]   REC_COUNT
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  a_start_code: assert property (START && !TRIP |-> STATUS == 2'h1) else $error("start");
  a_trip_code: assert property (TRIP |-> STATUS == 2'h2) else $error("trip code");
  a_block_code: assert property (BLOCKED |-> STATUS == 2'h3) else $error("block code");
  a_block_start: assert property (!(BLOCKED && START)) else $error("start with block");
  a_note_once: assert property (HMI_BLOCK_NOTE |=> !HMI_BLOCK_NOTE) else $error("note");
  a_note_cause: assert property (HMI_BLOCK_NOTE |-> ##[0:1] BLOCKED) else $error("note");
  a_evt_code: assert property (EVT_VALID |-> EVT_CODE != 2'h3) else $error("evt code");
  a_ring_size: assert property (REC_COUNT <= 4'hC) else $error("rec count");
  a_ttt_sign: assert property (!TIME_TO_TRIP[TMW]) else $error("ttt sign");
endmodule // jamp_core_sva
bind jamp_core jamp_core_sva #(.TMW(TMW)) u_sva (
  .CLK            (CLK),
  .SYS_RST        (SYS_RST),
  .STATUS         (STATUS),
  .START          (START),
  .TRIP           (TRIP),
  .BLOCKED        (BLOCKED),
  .HMI_BLOCK_NOTE (HMI_BLOCK_NOTE),
  .EVT_VALID      (EVT_VALID),
  .EVT_CODE       (EVT_CODE),
  .TIME_TO_TRIP   (TIME_TO_TRIP),
  .REC_COUNT      (REC_COUNT)
);

// *** verif/jamp_far.sv ***
`timescale 1ns/1ns
module jamp_far (
  input  wire       clk,
  input  wire       blk_req,
  input  wire       evt_valid,
  input  wire [1:0] evt_code,
  output reg        blk_q,
  output reg  [1:0] code_q
);
  initial blk_q = 1'b0;
  initial code_q = 2'h3;
  always @(posedge clk)
  begin
    blk_q <= #1 blk_req;
    if (evt_valid)
      code_q <= evt_code;
  end
endmodule // jamp_far

// *** verif/jamp_core_tb.sv ***
`timescale 1ns/1ns
module jamp_core_tb;
  reg         clk = 0, rst = 1, tick = 0, pick = 0, blk_req = 0, sw = 0, frc = 0;
  reg  [15:0] imax = 16'h012C, iset = 16'h0064;
  reg  [19:0] opd = 20'hFFFFF;
  wire        blk, ev, start, trip, ev_on;
  wire [3:0]  evf;
  wire [15:0] evc;
  wire [19:0] exp_t;
  wire [140:0] rrd;
  wire [1:0]  st, ec, code;
  wire [3:0]  rc;
  wire [15:0] ratio;
  integer     n_fail = 0, check_count = 0, cyc = 0;
  initial
  begin
    forever #20 clk = ~clk;
  end
  jamp_far i_far (.clk(clk), .blk_req(blk_req), .evt_valid(ev), .evt_code(ec),
    .blk_q(blk), .code_q(code));
  jamp_core i_dut (.CLK(clk), .SYS_RST(rst), .CYCLE_TICK(tick), .PICKUP(pick),
    .BLOCK_IN(blk), .TEST_BLOCK_SW(sw), .STAGE_FORCE_EN(frc),
    .OPERATE_DELAY(opd), .RELEASE_DELAY(20'h0), .I_MAX(imax), .I_SET(iset),
    .I_PRE20(imax), .I_PRE200(iset), .FAULT_TYPE(4'h1), .SETTING_GROUP_INDEX(3'h2),
    .TIME_STAMP({32'h0, imax}), .EVT_SEL(6'h15), .REC_RD_IDX(4'h0), .STATUS(st),
    .START(start), .TRIP(trip), .BLOCKED(), .HMI_BLOCK_NOTE(), .EVT_VALID(ev),
    .EVT_CODE(ec), .EVT_ON(ev_on), .EVT_TIME(), .EVT_CURRENT(evc), .EVT_FAULT(evf),
    .EXP_OP_TIME(exp_t), .TIME_TO_TRIP(), .RATIO(ratio), .REC_RD_DATA(rrd),
    .REC_COUNT(rc));
  task chk(input string nm, input [31:0] e, input [31:0] g);
    check_count = check_count + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // blocking goes through the far side, which adds one cycle of delay
  task go(input p, input b, input s, input f);
    pick = p;
    blk_req = b;
    sw = s;
    frc = f;
    repeat (2) @(posedge clk);
    #1 tick = 1;
    @(posedge clk);
    #1 tick = 0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task t_start;
    go(1, 0, 0, 0);
    chk("status", 16'h1, st);
    chk("trip", 16'h0, trip);
    chk("event", 16'h0, code);
    chk("ratio", 16'd300, ratio);
    chk("records", 16'h1, rc);
    chk("event on", 16'h1, ev_on);
    chk("event current", 16'h012C, evc);
    chk("record group", 16'h2, rrd[2:0]);
    chk("record remaining", 32'h000FFFFF, rrd[22:3]);
    chk("record fault", 16'h1, rrd[90:87]);
    $display("start test done");
  endtask
  task t_block_mid;
    go(1, 1, 0, 0);
    chk("start", 16'h0, start);
    $display("mid block test done");
  endtask
  task t_block_pick;
    go(0, 0, 0, 0);
    chk("status", 16'h0, st);
    go(1, 1, 0, 0);
    chk("status", 16'h3, st);
    chk("event", 16'h2, code);
    chk("records", 16'h3, rc);
    chk("event fault", 16'h1, evf);
    chk("expected time", 32'h000FFFFF, exp_t);
    $display("blocked pickup test done");
  endtask
  // zero operate delay lets the trip follow start within the short run
  task t_trip;
    go(0, 0, 0, 0);
    opd = 20'h0;
    go(1, 0, 0, 0);
    chk("trip", 16'h1, trip);
    chk("status", 16'h2, st);
    chk("event", 16'h1, code);
    chk("records", 16'h7, rc);
    $display("trip test done");
  endtask
  task t_switch;
    go(0, 0, 0, 0);
    go(1, 0, 1, 0);
    chk("status", 16'h1, st);
    go(0, 0, 0, 0);
    go(1, 0, 1, 1);
    chk("status", 16'h3, st);
    $display("switch test done");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    #1 rst = 0;
    chk("status", 16'h0, st);
    chk("records", 16'h0, rc);
    t_start;
    t_block_mid;
    t_block_pick;
    t_switch;
    t_trip;
    report_and_stop;
  end
endmodule // jamp_core_tb
